// file: hw/ahar_params.svh
`ifndef AHAR_PARAMS_SVH
`define AHAR_PARAMS_SVH

// =====================================================================
// Widths, clock and timing
`define AHAR_POS_W 32
`define AHAR_CLK_HZ 25000000
`define AHAR_EN_PULSE_US 1000
`define AHAR_EN_PULSE_CYC ((`AHAR_CLK_HZ / 1000000) * `AHAR_EN_PULSE_US)
`define AHAR_CNT_W 16

// =====================================================================
// Reset values and field positions
`define AHAR_POS_RST 32'h00000000
`define AHAR_STS_RST 16'h0000
`define AHAR_STS_CODE_MSB 15
`define AHAR_STS_CODE_LSB 8
`define AHAR_ALM_CODE_MSB 7
`define AHAR_ALM_CODE_LSB 0

`endif

// file: hw/ahar_pkg.sv
`include "ahar_params.svh"

package ahar_pkg;

  typedef logic signed [`AHAR_POS_W-1:0] ahar_pos_t;

  // Position set held by the controller
  typedef struct packed {
    ahar_pos_t commanded_position;
    ahar_pos_t feedback_position;
    ahar_pos_t encoder_count;
  } ahar_posset_t;

  // Answer of the driver to a position query
  typedef struct packed {
    ahar_pos_t position;
    logic [7:0] status_code;
    logic [7:0] alarm_code;
  } ahar_drv_info_t;

  typedef enum logic [1:0] {
    AHAR_EN_IDLE = 2'b01,
    AHAR_EN_PULSE = 2'b10
  } ahar_en_state_t;

endpackage

// file: hw/ahar_core.sv
`timescale 1ns/1ns
`include "ahar_params.svh"

module ahar_core
  import ahar_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_home_reset_cmd,
  input wire logic i_post_alarm_enable_command,
  input wire logic i_driver_position_query,
  input wire logic i_driver_position_sync,
  input wire ahar_drv_info_t i_drv_info,
  input wire logic i_home_seek_done,
  input wire logic i_home_deviation_clear_cfg,
  input wire logic i_pos_load,
  input wire ahar_posset_t i_pos_in,
  output ahar_posset_t o_pos,
  output ahar_pos_t o_position_deviation,
  output ahar_pos_t o_driver_position,
  output logic [15:0] o_driver_status_word,
  output logic o_home_reset_out,
  output logic o_enable_request_out,
  output logic o_deviation_clear_out
);

  localparam int unsigned EN_CYC = `AHAR_EN_PULSE_CYC;

  ahar_posset_t pos_reg;
  ahar_posset_t pos_next;
  ahar_pos_t dev;
  ahar_pos_t drv_pos_reg;
  logic [15:0] sts_reg;
  logic home_out_reg;
  logic dcl_out_reg;
  ahar_en_state_t en_state_reg;
  logic [`AHAR_CNT_W-1:0] en_cnt_reg;

  // =====================================================================
  // Position bookkeeping
  assign dev = pos_reg.commanded_position - pos_reg.feedback_position;

  always_comb begin
    pos_next = pos_reg;
    if (i_home_reset_cmd) begin
      pos_next.commanded_position = `AHAR_POS_RST;
      // Shift both by the same amount so deviation survives
      pos_next.feedback_position = pos_reg.feedback_position - pos_reg.commanded_position;
      pos_next.encoder_count = pos_reg.encoder_count - pos_reg.commanded_position;
    end else if (i_driver_position_sync) begin
      pos_next.commanded_position = i_drv_info.position;
      pos_next.feedback_position = pos_reg.feedback_position
                                   + (i_drv_info.position - pos_reg.commanded_position);
      pos_next.encoder_count = pos_reg.encoder_count
                               + (i_drv_info.position - pos_reg.commanded_position);
    end else if (i_pos_load) begin
      pos_next = i_pos_in;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pos_reg <= '0;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // =====================================================================
  // Driver query capture; sync also refreshes the stored answer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      drv_pos_reg <= `AHAR_POS_RST;
      sts_reg <= `AHAR_STS_RST;
    end else if (i_driver_position_query || i_driver_position_sync) begin
      drv_pos_reg <= i_drv_info.position;
      sts_reg <= {i_drv_info.status_code, i_drv_info.alarm_code};
    end
  end

  // =====================================================================
  // Home reset output (home command or seek done) and deviation clear output (seek done with cfg), one cycle later
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      home_out_reg <= 1'b0;
    end else begin
      home_out_reg <= i_home_reset_cmd || i_home_seek_done;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dcl_out_reg <= 1'b0;
    end else begin
      dcl_out_reg <= i_home_seek_done && i_home_deviation_clear_cfg;
    end
  end

  // =====================================================================
  // Enable request pulse; a new command during the pulse is ignored
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      en_state_reg <= AHAR_EN_IDLE;
      en_cnt_reg <= '0;
    end else begin
      case (en_state_reg)
        AHAR_EN_IDLE: begin
          if (i_post_alarm_enable_command) begin
            en_state_reg <= AHAR_EN_PULSE;
            en_cnt_reg <= '0;
          end
        end
        AHAR_EN_PULSE: begin
          if (en_cnt_reg == `AHAR_CNT_W'(EN_CYC - 1)) begin
            en_state_reg <= AHAR_EN_IDLE;
          end else begin
            en_cnt_reg <= en_cnt_reg + 1'b1;
          end
        end
        default: en_state_reg <= AHAR_EN_IDLE;
      endcase
    end
  end

  assign o_pos = pos_reg;
  assign o_position_deviation = dev;
  assign o_driver_position = drv_pos_reg;
  assign o_driver_status_word = sts_reg;
  assign o_home_reset_out = home_out_reg;
  assign o_deviation_clear_out = dcl_out_reg;
  assign o_enable_request_out = (en_state_reg == AHAR_EN_PULSE);

  // =====================================================================
  // Checks
  property p_home_zero;
    @(posedge i_clk) disable iff (i_reset)
      i_home_reset_cmd |=> (pos_reg.commanded_position == 0);
  endproperty
  a_home_zero: assert property (p_home_zero) else $error("home reset not zero");

  property p_home_dev;
    @(posedge i_clk) disable iff (i_reset)
      i_home_reset_cmd |=> (pos_reg.feedback_position == -$past(dev));
  endproperty
  a_home_dev: assert property (p_home_dev) else $error("deviation lost");

  property p_home_out;
    @(posedge i_clk) disable iff (i_reset)
      (i_home_reset_cmd || i_home_seek_done) |=> o_home_reset_out;
  endproperty
  a_home_out: assert property (p_home_out) else $error("home out missing");

  property p_en_start;
    @(posedge i_clk) disable iff (i_reset)
      (i_post_alarm_enable_command && !o_enable_request_out) |=> o_enable_request_out;
  endproperty
  a_en_start: assert property (p_en_start) else $error("enable not raised");

  // =====================================================================
  // Pulse width watch
  // A window of 25000 cycles is too long to unroll, so an independent
  // counter measures the high time and the checks look at its value
  logic [`AHAR_CNT_W-1:0] en_len_cnt_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      en_len_cnt_reg <= '0;
    end else if (o_enable_request_out) begin
      en_len_cnt_reg <= en_len_cnt_reg + 1'b1;
    end else begin
      en_len_cnt_reg <= '0;
    end
  end

  property p_en_len;
    @(posedge i_clk) disable iff (i_reset)
      $fell(o_enable_request_out) |-> (en_len_cnt_reg == `AHAR_CNT_W'(EN_CYC));
  endproperty
  a_en_len: assert property (p_en_len) else $error("enable width wrong");

  property p_en_max;
    @(posedge i_clk) disable iff (i_reset)
      o_enable_request_out |-> (en_len_cnt_reg < `AHAR_CNT_W'(EN_CYC));
  endproperty
  a_en_max: assert property (p_en_max) else $error("enable held too long");

  property p_seek_home;
    @(posedge i_clk) disable iff (i_reset)
      i_home_seek_done |=> o_home_reset_out;
  endproperty
  a_seek_home: assert property (p_seek_home) else $error("seek home missing");

  property p_dcl;
    @(posedge i_clk) disable iff (i_reset)
      o_deviation_clear_out |-> $past(i_home_seek_done && i_home_deviation_clear_cfg);
  endproperty
  a_dcl: assert property (p_dcl) else $error("bad deviation clear");

  property p_dcl_set;
    @(posedge i_clk) disable iff (i_reset)
      (i_home_seek_done && i_home_deviation_clear_cfg) |=> o_deviation_clear_out;
  endproperty
  a_dcl_set: assert property (p_dcl_set) else $error("deviation clear missing");

  property p_sts;
    @(posedge i_clk) disable iff (i_reset)
      i_driver_position_query |=>
        (o_driver_status_word == $past({i_drv_info.status_code, i_drv_info.alarm_code}));
  endproperty
  a_sts: assert property (p_sts) else $error("status word wrong");

  property p_sync;
    @(posedge i_clk) disable iff (i_reset)
      (i_driver_position_sync && !i_home_reset_cmd) |=>
        (pos_reg.commanded_position == $past(i_drv_info.position)) && (dev == $past(dev));
  endproperty
  a_sync: assert property (p_sync) else $error("sync wrong");

  c_home: cover property (@(posedge i_clk) disable iff (i_reset) i_home_reset_cmd);
  c_en: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_enable_request_out));
  c_dcl: cover property (@(posedge i_clk) disable iff (i_reset) o_deviation_clear_out);
  c_sync: cover property (@(posedge i_clk) disable iff (i_reset) i_driver_position_sync);

endmodule

// file: tb/ahar_drv_model.sv
`timescale 1ns/1ns
// ====================================================
// Motor driver with battery-backed position counter
module ahar_drv_model
  import ahar_pkg::*;
#(
  parameter ahar_pos_t START = 32'h00001234,
  parameter ahar_pos_t OFS = 32'h00000040,
  parameter logic [7:0] STS = 8'h5A,
  parameter logic [7:0] LOSS = 8'h30
)(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_home_reset_out,
  input wire logic i_low_batt,
  output ahar_drv_info_t o_info
);
  // Fresh battery: no stored home yet, so the loss code shows from power-on
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_info <= '{START, STS, LOSS};
    end else if (i_low_batt) begin
      o_info.alarm_code <= LOSS;
    end else if (i_home_reset_out) begin
      // A nonzero home offset leaves the two position counts apart
      o_info.position <= OFS;
      o_info.alarm_code <= 8'h00;
    end
  end
endmodule

// file: tb/absolute_home_alarm_release_bench.sv
`timescale 1ns/1ns
module absolute_home_alarm_release_bench;
  import ahar_pkg::*;
  localparam ahar_pos_t START = 32'h00001234;
  localparam ahar_pos_t OFS = 32'h00000040;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_home_reset_cmd = 1'b0;
  logic i_post_alarm_enable_command = 1'b0;
  logic i_driver_position_query = 1'b0;
  logic i_driver_position_sync = 1'b0;
  logic i_home_seek_done = 1'b0;
  logic i_home_deviation_clear_cfg = 1'b0;
  logic i_pos_load = 1'b0;
  logic i_low_batt = 1'b0;
  ahar_posset_t i_pos_in = '0;
  ahar_drv_info_t drv_info;
  ahar_posset_t o_pos;
  ahar_pos_t o_position_deviation;
  ahar_pos_t o_driver_position;
  logic [15:0] o_driver_status_word;
  logic o_home_reset_out;
  logic o_enable_request_out;
  logic o_deviation_clear_out;
  int n_mismatch = 0;
  int compares = 0;

  ahar_core ahar_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_home_reset_cmd(i_home_reset_cmd),
    .i_post_alarm_enable_command(i_post_alarm_enable_command),
    .i_driver_position_query(i_driver_position_query),
    .i_driver_position_sync(i_driver_position_sync), .i_drv_info(drv_info),
    .i_home_seek_done(i_home_seek_done), .i_home_deviation_clear_cfg(i_home_deviation_clear_cfg),
    .i_pos_load(i_pos_load), .i_pos_in(i_pos_in), .o_pos(o_pos),
    .o_position_deviation(o_position_deviation), .o_driver_position(o_driver_position),
    .o_driver_status_word(o_driver_status_word), .o_home_reset_out(o_home_reset_out),
    .o_enable_request_out(o_enable_request_out), .o_deviation_clear_out(o_deviation_clear_out));
  ahar_drv_model #(.START(START), .OFS(OFS)) ahar_drv_model_i (.i_clk(i_clk),
    .i_reset(i_reset), .i_home_reset_out(o_home_reset_out), .i_low_batt(i_low_batt),
    .o_info(drv_info));

  // ====================================================
  // Shared steps
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task step;
    @(negedge i_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ====================================================
  // Scenarios
  task t_query(input logic [31:0] pos, input logic [31:0] word);
    i_driver_position_query = 1'b1;
    step;
    i_driver_position_query = 1'b0;
    chk(o_driver_position, pos);
    chk({16'h0000, o_driver_status_word}, word);
  endtask
  task t_home;
    i_pos_in = '{32'h00000064, 32'h0000005A, 32'h00000050};
    i_pos_load = 1'b1;
    step;
    // Load stays high with the home command: it must lose
    i_home_reset_cmd = 1'b1;
    step;
    i_home_reset_cmd = 1'b0;
    i_pos_load = 1'b0;
    chk(o_pos.commanded_position, 32'h00000000);
    chk(o_pos.feedback_position, 32'hFFFFFFF6);
    chk(o_pos.encoder_count, 32'hFFFFFFEC);
    chk(o_position_deviation, 32'h0000000A);
    chk({31'h0, o_home_reset_out}, 32'h00000001);
    step;
    chk({31'h0, o_home_reset_out}, 32'h00000000);
  endtask
  task t_sync;
    i_driver_position_sync = 1'b1;
    step;
    i_driver_position_sync = 1'b0;
    chk(o_pos.commanded_position, OFS);
    chk(o_pos.feedback_position, 32'h00000036);
    chk(o_pos.encoder_count, 32'h0000002C);
  endtask
  task t_enable;
    i_post_alarm_enable_command = 1'b1;
    step;
    i_post_alarm_enable_command = 1'b0;
    chk({31'h0, o_enable_request_out}, 32'h00000001);
    repeat (100) step;
    i_post_alarm_enable_command = 1'b1;
    step;
    i_post_alarm_enable_command = 1'b0;
    repeat (24898) step;
    chk({31'h0, o_enable_request_out}, 32'h00000001);
    step;
    chk({31'h0, o_enable_request_out}, 32'h00000000);
  endtask
  task t_seek(input logic cfg);
    i_home_deviation_clear_cfg = cfg;
    i_home_seek_done = 1'b1;
    step;
    i_home_seek_done = 1'b0;
    chk({31'h0, o_home_reset_out}, 32'h00000001);
    chk({31'h0, o_deviation_clear_out}, {31'h0, cfg});
    step;
    chk({31'h0, o_deviation_clear_out}, 32'h00000000);
  endtask

  initial begin
    repeat (8) step;
    i_reset = 1'b0;
    t_query(START, 32'h00005A30);
    t_home;
    t_query(OFS, 32'h00005A00);
    t_sync;
    i_low_batt = 1'b1;
    step;
    i_low_batt = 1'b0;
    t_query(OFS, 32'h00005A30);
    t_enable;
    t_seek(1'b1);
    t_seek(1'b0);
    complete_run;
  end
  initial begin
    #4000000;
    n_mismatch++;
    complete_run;
  end
endmodule
